// File: rtl/flash_pins_defs.vh
`ifndef FLASH_PINS_DEFS_VH
`define FLASH_PINS_DEFS_VH
// ==========================================================
// Bit and byte framing
`define BYTE_BITS 8
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_LAST_DUAL 3'h3
`define BIT_CNT_ZERO 3'h0
`define BIT_CNT_FIRST 3'h1
// ==========================================================
// Line modes
`define LINE_SINGLE 2'h0
`define LINE_DUAL_OUT 2'h1
`define LINE_DUAL_IN 2'h2
// ==========================================================
// Protect size field
`define PROTECT_W 3
`define PROTECT_RESET 3'h0
// ==========================================================
// Synchroniser reset level (pins idle high)
`define SYNC_IDLE 1'h1
// Select chain resets low: a pin held low since power-up shows no fall
`define CS_SYNC_RESET 2'h0
`define CS_PREV_RESET 1'h0
`endif

// File: rtl/flash_fifo.v
`timescale 1ns/100ps
// ==========================================================
// Word FIFO, flip-flop storage
module flash_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  reg [AW:0] fill;
  wire do_wr;
  wire do_rd;
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  // Pointers and fill level
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}}
                  : rd_ptr + 1'b1;
      end
      fill <= fill + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
  // Storage; no reset needed for data words
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // Combinational head word, read straight from storage
  always @* begin
    out_data = mem[rd_ptr[AW-1:0]];
  end
endmodule // flash_fifo

// File: rtl/serial_flash_pin_interface.v
`timescale 1ns/100ps
// Functional notes
// - Read data changes on falling clock edges
// - Dual program: out line sampled too
// - Sample in line on rising edges
// - Dual read: in line drives second bit
// - Deselected: out line high impedance
// - Standby after deselect once busy ends
// - Select low means active power
// - Ignore commands before first select edge
// - Pause suspends without deselecting
// - Paused: outputs off, inputs ignored
// - Write protect freezes protect size bits
// - Clock idles low or high, both work
`include "flash_pins_defs.vh"
module serial_flash_pin_interface #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire sclk_pin,
  input wire chip_sel_n,
  input wire pause_n,
  input wire write_protect_n,
  input wire primary_in_line_i,
  output reg primary_in_line_o,
  output wire primary_in_line_oe_n,
  input wire primary_out_line_i,
  output reg primary_out_line_o,
  output wire primary_out_line_oe_n,
  input wire [1:0] line_mode,
  output wire rx_valid,
  input wire rx_ready,
  output wire [7:0] rx_byte,
  output reg rx_overrun,
  input wire tx_valid,
  output wire tx_ready,
  input wire [7:0] tx_byte,
  output reg tx_underrun,
  input wire busy,
  input wire protect_wr_req,
  input wire [2:0] protect_wr_data,
  output reg [2:0] protect_size,
  output wire protect_frozen,
  output reg selected,
  output reg active_power,
  output reg powered_up_seen
);
  // ========================================================
  // Input synchronisers
  reg [1:0] sclk_s;
  reg [1:0] cs_s;
  reg [1:0] hold_s;
  reg [1:0] wp_s;
  reg [1:0] din_s;
  reg [1:0] dout_s;
  reg sclk_prev;
  // Two flops per pin; first stage read only by the second
  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_s <= 2'h0;
      cs_s <= `CS_SYNC_RESET; // No false fall after reset
      hold_s <= {2{`SYNC_IDLE}};
      wp_s <= {2{`SYNC_IDLE}};
      din_s <= 2'h0;
      dout_s <= 2'h0;
      sclk_prev <= 1'h0;
    end else begin
      sclk_s <= {sclk_s[0], sclk_pin};
      cs_s <= {cs_s[0], chip_sel_n};
      hold_s <= {hold_s[0], pause_n};
      wp_s <= {wp_s[0], write_protect_n};
      din_s <= {din_s[0], primary_in_line_i};
      dout_s <= {dout_s[0], primary_out_line_i};
      sclk_prev <= sclk_s[1];
    end
  end
  wire cs_n = cs_s[1];
  wire paused = ~hold_s[1] & ~cs_n;
  // Edges only count while selected and not paused
  wire live = ~cs_n & ~paused & powered_up_seen;
  wire sclk_rise = live & sclk_s[1] & ~sclk_prev;
  wire sclk_fall = live & ~sclk_s[1] & sclk_prev;
  reg cs_prev;
  // ========================================================
  // Selection and power state
  always @(posedge clk) begin
    if (sys_rst) begin
      cs_prev <= `CS_PREV_RESET;
      selected <= 1'h0;
      active_power <= 1'h0;
      powered_up_seen <= 1'h0;
    end else begin
      cs_prev <= cs_n;
      if (cs_prev & ~cs_n) begin
        powered_up_seen <= 1'h1;
      end
      selected <= ~cs_n & (powered_up_seen | cs_prev);
      active_power <= ~cs_n | busy;
    end
  end
  wire cs_rise = ~cs_prev & cs_n;
  wire cs_fall = cs_prev & ~cs_n;
  // ========================================================
  // Receive shifter
  reg [7:0] rx_shift;
  reg [2:0] rx_cnt;
  reg rx_push;
  reg [7:0] rx_word;
  wire fifo_in_ready;
  wire dual_in = (line_mode == `LINE_DUAL_IN);
  wire dual_out = (line_mode == `LINE_DUAL_OUT);
  wire [2:0] rx_last = dual_in ? `BIT_CNT_LAST_DUAL : `BIT_CNT_LAST;
  reg [7:0] next_rx_shift;
  // Shift register next value, one or two bits per edge
  always @* begin
    if (dual_in) begin
      next_rx_shift = {rx_shift[5:0], dout_s[1], din_s[1]};
    end else begin
      next_rx_shift = {rx_shift[6:0], din_s[1]};
    end
  end
  // Rising edge sampling; deselect drops partial bits
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_shift <= 8'h00;
      rx_cnt <= `BIT_CNT_ZERO;
      rx_push <= 1'h0;
      rx_word <= 8'h00;
      rx_overrun <= 1'h0;
    end else begin
      rx_push <= 1'h0;
      if (cs_rise) begin
        rx_cnt <= `BIT_CNT_ZERO;
        rx_shift <= 8'h00;
      end else if (sclk_rise & ~dual_out) begin
        rx_shift <= next_rx_shift;
        if (rx_cnt == rx_last) begin
          rx_cnt <= `BIT_CNT_ZERO;
          rx_word <= next_rx_shift;
          rx_push <= 1'h1;
        end else begin
          rx_cnt <= rx_cnt + 1'b1;
        end
      end
      // Sticky overrun: a full FIFO loses the byte
      if (rx_push & ~fifo_in_ready) begin
        rx_overrun <= 1'h1;
      end
    end
  end
  flash_fifo #(
    .WIDTH(`BYTE_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_byte)
  );
  // ========================================================
  // Transmit shifter
  reg [7:0] tx_shift;
  reg [2:0] tx_cnt;
  reg tx_loaded;
  wire [2:0] tx_last = dual_out ? `BIT_CNT_LAST_DUAL : `BIT_CNT_LAST;
  assign tx_ready = sclk_fall & ~tx_loaded & ~dual_in;
  // Falling edge shift-out; a byte starts on the fall before its first rise
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_shift <= 8'h00;
      tx_cnt <= `BIT_CNT_ZERO;
      tx_loaded <= 1'h0;
      tx_underrun <= 1'h0;
      primary_out_line_o <= 1'h0;
      primary_in_line_o <= 1'h0;
    end else if (cs_rise) begin
      tx_cnt <= `BIT_CNT_ZERO;
      tx_loaded <= 1'h0;
    end else if (cs_fall & ~sclk_s[1]) begin
      // Clock idles low: first fall is mid-byte, so that byte is ones
      tx_shift <= 8'hFF;
      tx_cnt <= `BIT_CNT_FIRST;
      tx_loaded <= 1'h1;
    end else if (sclk_fall & ~dual_in) begin
      if (~tx_loaded) begin
        if (~tx_valid) begin
          tx_underrun <= 1'h1;
        end
        // Missing data shifts out ones, like an idle line
        if (dual_out) begin
          primary_out_line_o <= tx_valid ? tx_byte[7] : 1'h1;
          primary_in_line_o <= tx_valid ? tx_byte[6] : 1'h1;
          tx_shift <= tx_valid ? {tx_byte[5:0], 2'h3} : 8'hFF;
        end else begin
          primary_out_line_o <= tx_valid ? tx_byte[7] : 1'h1;
          tx_shift <= tx_valid ? {tx_byte[6:0], 1'h1} : 8'hFF;
        end
        tx_loaded <= (tx_last != `BIT_CNT_ZERO);
        tx_cnt <= `BIT_CNT_FIRST;
      end else begin
        if (dual_out) begin
          primary_out_line_o <= tx_shift[7];
          primary_in_line_o <= tx_shift[6];
          tx_shift <= {tx_shift[5:0], 2'h3};
        end else begin
          primary_out_line_o <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'h1};
        end
        if (tx_cnt == tx_last) begin
          tx_cnt <= `BIT_CNT_ZERO;
          tx_loaded <= 1'h0;
        end else begin
          tx_cnt <= tx_cnt + 1'b1;
        end
      end
    end
  end
  // Drivers off when deselected, paused, or lines are inputs
  assign primary_out_line_oe_n = cs_n | paused | dual_in |
                                 ~powered_up_seen;
  assign primary_in_line_oe_n = cs_n | paused | ~dual_out |
                                ~powered_up_seen;
  // ========================================================
  // Protect size, frozen while write protect held
  assign protect_frozen = ~wp_s[1];
  always @(posedge clk) begin
    if (sys_rst) begin
      protect_size <= `PROTECT_RESET;
    end else if (protect_wr_req & ~protect_frozen) begin
      protect_size <= protect_wr_data;
    end
  end
endmodule // serial_flash_pin_interface

// File: verif/flash_pins_sva.sv
`timescale 1ns/100ps
// ==========================================
// Pin rule checker
module flash_pins_sva (
  input wire clk,
  input wire sys_rst,
  input wire chip_sel_n,
  input wire pause_n,
  input wire busy,
  input wire [1:0] line_mode,
  input wire primary_in_line_oe_n,
  input wire primary_out_line_oe_n,
  input wire [2:0] protect_size,
  input wire protect_frozen,
  input wire selected,
  input wire active_power,
  input wire powered_up_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins pass two sync flops, so levels get a few cycles
  desel_hiz_a: assert property (
    chip_sel_n [*4] |-> primary_out_line_oe_n) else $error("desel drive");
  pause_hiz_a: assert property (
    !pause_n [*4] |-> primary_out_line_oe_n) else $error("pause drive");
  dual_prog_a: assert property (
    (line_mode == 2'h2) [*2] |-> primary_out_line_oe_n) else $error("dp");
  in_line_a: assert property (
    (line_mode != 2'h1) [*2] |-> primary_in_line_oe_n) else $error("in");
  first_fall_a: assert property (
    !powered_up_seen |-> !selected) else $error("early select");
  sel_power_a: assert property (
    (!chip_sel_n && powered_up_seen) [*4] |-> selected && active_power)
    else $error("not active");
  power_standby_a: assert property (
    (chip_sel_n && !busy) [*5] |-> !active_power) else $error("standby");
  size_freeze_a: assert property (
    protect_frozen |=> $stable(protect_size)) else $error("freeze");
endmodule // flash_pins_sva
bind serial_flash_pin_interface flash_pins_sva i_sva (.*);

// File: verif/spi_host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host controller model, clock modes 0 and 3
module spi_host_model (
  input wire clk,
  input wire line0,
  input wire line1,
  output reg sclk,
  output reg cs_n,
  output reg d0,
  output reg d1
);
  reg cpol = 1'b0;
  // Select starts low; the bench makes the first fall
  initial {sclk, cs_n, d0, d1} = 4'h0;
  // Bit or bit pair per 9 clk, MSB first; read sampled late in high
  task automatic xfer(input integer n, input dual, input [7:0] tx,
    output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = n - 1; i >= 0; i = i - 1) begin
        @(posedge clk);
        sclk <= 1'b0;
        if (dual) {d1, d0} <= tx[2*i+:2];
        else d0 <= tx[i];
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        rx = dual ? {rx[5:0], line1, line0} : {rx[6:0], line1};
      end
      @(posedge clk);
      sclk <= cpol;
      {d1, d0} <= ~{d1, d0}; // Released lines do not keep last value
    end
  endtask
  // Clock parks before select moves, never on the same edge
  task automatic sel(input v);
    begin
      @(posedge clk);
      sclk <= cpol;
      repeat (8) @(posedge clk);
      cs_n <= v;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // spi_host_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg pause_n = 1'b1;
  reg write_protect_n = 1'b1;
  reg rx_ready = 1'b0;
  reg busy = 1'b0;
  reg protect_wr_req = 1'b0;
  reg [2:0] protect_wr_data = 3'h0;
  reg [1:0] line_mode = 2'h0;
  reg [7:0] tx_byte = 8'h4B;
  reg tx_valid = 1'b1;
  integer tx_takes = 0;
  reg [7:0] r;
  integer fail_count = 0;
  integer total_checks = 0;
  integer k;
  wire sclk, cs_n, d0, d1, in_o, in_oe_n, out_o, out_oe_n, rx_valid;
  wire rx_overrun, selected, active_power, pup, frozen;
  wire tx_ready, tx_underrun;
  wire [7:0] rx_byte;
  wire [2:0] protect_size;
  // Resolved data lines
  wire line0 = in_oe_n ? d0 : in_o;
  wire line1 = out_oe_n ? d1 : out_o;
  // ==========================================
  // Clock 25 MHz
  always #20 clk = ~clk;
  spi_host_model h (.clk(clk), .line0(line0), .line1(line1), .sclk(sclk),
    .cs_n(cs_n), .d0(d0), .d1(d1));
  serial_flash_pin_interface i_dut (.clk(clk), .sys_rst(sys_rst),
    .sclk_pin(sclk), .chip_sel_n(cs_n), .pause_n(pause_n),
    .write_protect_n(write_protect_n), .primary_in_line_i(line0),
    .primary_in_line_o(in_o), .primary_in_line_oe_n(in_oe_n),
    .primary_out_line_i(line1), .primary_out_line_o(out_o),
    .primary_out_line_oe_n(out_oe_n), .line_mode(line_mode),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
    .rx_overrun(rx_overrun), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_underrun(tx_underrun), .busy(busy),
    .protect_wr_req(protect_wr_req), .protect_wr_data(protect_wr_data),
    .protect_size(protect_size), .protect_frozen(frozen),
    .selected(selected), .active_power(active_power),
    .powered_up_seen(pup));
  // Byte fetches by the transmit shifter
  always @(posedge clk) begin
    if (tx_ready) tx_takes <= tx_takes + 1;
  end
  // ==========================================
  // Shared helpers
  task chk(input [7:0] g, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Pops one byte; bounded wait since a lost push would hang
  task rxchk(input [7:0] e);
    integer n;
    begin
      n = 0;
      @(negedge clk);
      while (rx_valid !== 1'b1 && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 300) begin
        chk(8'(rx_valid), 8'h01);
        results;
      end else begin
        chk(rx_byte, e);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d fails %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_first;
    begin
      h.xfer(8, 1'b0, 8'hA5, r);
      @(negedge clk);
      chk(8'(rx_valid | selected | pup), 8'h00);
      h.sel(1'b1);
      h.sel(1'b0);
      chk(8'({selected, active_power, pup}), 8'h07);
    end
  endtask
  task t_single;
    begin
      h.xfer(8, 1'b0, 8'hA5, r);
      h.xfer(8, 1'b0, 8'h96, r);
      chk(r, tx_byte);
      rxchk(8'hA5);
      rxchk(8'h96);
      h.sel(1'b1);
      chk(8'(out_oe_n), 8'h01);
    end
  endtask
  task t_mode3;
    begin
      h.cpol = 1'b1;
      h.sel(1'b0);
      h.xfer(8, 1'b0, 8'h5A, r);
      chk(r, tx_byte);
      rxchk(8'h5A);
      h.sel(1'b1);
      h.cpol = 1'b0;
    end
  endtask
  task t_partial;
    begin
      h.sel(1'b0);
      h.xfer(4, 1'b0, 8'h0F, r);
      h.sel(1'b1);
      h.sel(1'b0);
      h.xfer(8, 1'b0, 8'hC3, r);
      rxchk(8'hC3);
    end
  endtask
  // Clocks while paused must leave the half byte intact
  task t_pause;
    begin
      h.xfer(4, 1'b0, 8'h0B, r);
      pause_n <= 1'b0;
      h.xfer(4, 1'b0, 8'h0F, r);
      chk(8'({out_oe_n, selected}), 8'h03);
      repeat (8) @(posedge clk);
      pause_n <= 1'b1;
      h.xfer(4, 1'b0, 8'h05, r);
      rxchk(8'hB5);
    end
  endtask
  task t_dual;
    begin
      h.sel(1'b1);
      line_mode <= 2'h2;
      h.sel(1'b0);
      h.xfer(4, 1'b1, 8'h6C, r);
      rxchk(8'h6C);
      h.sel(1'b1);
      line_mode <= 2'h1;
      tx_byte <= 8'hD2;
      h.sel(1'b0);
      h.xfer(4, 1'b1, 8'h00, r);
      h.xfer(4, 1'b1, 8'h00, r);
      chk(r, tx_byte);
      h.sel(1'b1);
      line_mode <= 2'h0;
    end
  endtask
  // Reader stalls: nine bytes into eight words
  task t_fill;
    begin
      rx_ready <= 1'b1;
      repeat (20) @(posedge clk);
      rx_ready <= 1'b0;
      h.sel(1'b0);
      for (k = 0; k < 9; k = k + 1) h.xfer(8, 1'b0, 8'h10 + k[7:0], r);
      h.sel(1'b1);
      chk(8'(rx_overrun), 8'h01);
      for (k = 0; k < 8; k = k + 1) rxchk(8'h10 + k[7:0]);
      @(negedge clk);
      chk(8'(rx_valid), 8'h00);
    end
  endtask
  task t_power;
    begin
      h.sel(1'b0);
      busy <= 1'b1;
      h.sel(1'b1);
      chk(8'(active_power), 8'h01);
      busy <= 1'b0;
      repeat (8) @(posedge clk);
      chk(8'(active_power), 8'h00);
    end
  endtask
  // No byte offered: ones go out and the underrun flag sticks
  task t_under;
    integer n0;
    begin
      n0 = tx_takes;
      chk(8'(tx_underrun), 8'h00);
      tx_valid <= 1'b0;
      h.sel(1'b0);
      h.xfer(8, 1'b0, 8'h00, r);
      h.xfer(8, 1'b0, 8'h00, r);
      repeat (4) @(posedge clk);
      chk(r, 8'hFF);
      chk(8'(tx_underrun), 8'h01);
      chk(8'(tx_takes - n0), 8'h02);
      h.sel(1'b1);
      tx_valid <= 1'b1;
      rxchk(8'h00);
      rxchk(8'h00);
    end
  endtask
  task prot(input [2:0] d);
    begin
      protect_wr_data <= d;
      protect_wr_req <= 1'b1;
      @(posedge clk);
      protect_wr_req <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task t_protect;
    begin
      prot(3'h3);
      chk(8'(protect_size), 8'h03);
      write_protect_n <= 1'b0;
      repeat (8) @(posedge clk);
      prot(3'h5);
      chk(8'({frozen, protect_size}), 8'h0B);
    end
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_first;
    t_single;
    t_mode3;
    t_partial;
    t_pause;
    t_dual;
    t_fill;
    t_power;
    t_under;
    t_protect;
    results;
  end
endmodule // tb_top
